// File: rtl/ipg_pkg.sv
// Shared constants for the inverter protection and gate-gating block.
// Assumes a single free-running 40 MHz logic clock; all times below are
// turned into cycle counts here so both design files agree on them.
package ipg_pkg;

   // Logic clock rate in MHz (25 ns period)
   localparam int CLK_FREQ_MHZ = 40;

   // Number of inverter phases
   localparam int PHASES = 3;

   // Least time to whole cycles, rounded up, never below one
   function automatic int ipg_cyc_least(input int time_ns);
      int cyc;
      cyc = (time_ns * CLK_FREQ_MHZ + 999) / 1000;
      return (cyc < 1) ? 1 : cyc;
   endfunction : ipg_cyc_least

   // Supply undervoltage noise filter, ns
   localparam int UV_FILT_NS = 3000;
   // High-side shutdown input filter, ns
   localparam int SD_FILT_NS = 3300;
   // Least low pulse on the fault line taken as a shutdown, ns
   localparam int FO_IN_NS = 6000;
   // Blanking time for limit and trip comparators, ns
   localparam int BLANK_NS = 2000;
   // Fault hold time after an overcurrent trip, ns
   localparam int OCP_HOLD_NS = 25000;

   // Derived cycle counts
   localparam int UV_FILT_CYC = ipg_cyc_least(UV_FILT_NS);
   localparam int SD_FILT_CYC = ipg_cyc_least(SD_FILT_NS);
   localparam int FO_IN_CYC = ipg_cyc_least(FO_IN_NS);
   localparam int BLANK_CYC = ipg_cyc_least(BLANK_NS);
   localparam int OCP_HOLD_CYC = ipg_cyc_least(OCP_HOLD_NS);

   // Hold counter width
   localparam int HOLD_W = $clog2(OCP_HOLD_CYC + 1);

   // Bit positions inside the undervoltage filter vector
   localparam int UV_HS_STOP_LSB = 0;
   localparam int UV_HS_START_LSB = 3;
   localparam int UV_LS_STOP_BIT = 6;
   localparam int UV_LS_START_BIT = 7;
   localparam int UV_W = 8;

   // Overcurrent trip sequencer states
   typedef enum logic {
      OCP_IDLE = 1'b0,
      OCP_HOLD = 1'b1
   } ipg_ocp_state_t;

endpackage : ipg_pkg

// File: rtl/ipg_filt_if.sv
// Carrier between the protection core and its input filters.
// Assumes the core drives raw and the filter drives filt on the same clock.
`timescale 1ns/10ps
interface ipg_filt_if #(
   parameter int W = 1
);
   logic [W-1:0] raw; // Unfiltered indications
   logic [W-1:0] filt; // Filtered, registered indications

   // Side that owns the raw indications
   modport src (output raw, input filt);
   // Side that filters them
   modport flt (input raw, output filt);
endinterface : ipg_filt_if

// File: rtl/ipg_filter.sv
// Persistence filter: each channel takes a new level only after the raw
// level has differed for COUNT cycles. With SYM=0 a low raw level clears
// the channel at once, which suits blanking-type detectors.
// Assumes raw is synchronous to clk_i.
`timescale 1ns/10ps
module ipg_filter
   import ipg_pkg::*;
#(
   parameter int W = 1,
   parameter int COUNT = 4,
   parameter bit SYM = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   ipg_filt_if.flt f
);
   localparam int CW = $clog2(COUNT + 1);

   // Whole state of the filter
   typedef struct packed {
      logic [W-1:0][CW-1:0] cnt; // Cycles of disagreement per channel
      logic [W-1:0] out;         // Filtered level per channel
   } ipg_filt_state_t;

   ipg_filt_state_t s_q;
   ipg_filt_state_t s_d;

   // Next state per channel
   always_comb begin
      s_d = s_q;
      for (int i = 0; i < W; i++) begin
         if (f.raw[i] == s_q.out[i]) begin
            // Agreement restarts the count, so glitches never add up
            s_d.cnt[i] = '0;
         end else if (!SYM && !f.raw[i]) begin
            // Fast release for one-sided detectors
            s_d.out[i] = 1'b0;
            s_d.cnt[i] = '0;
         end else if (s_q.cnt[i] == CW'(COUNT - 1)) begin
            s_d.out[i] = f.raw[i];
            s_d.cnt[i] = '0;
         end else begin
            s_d.cnt[i] = s_q.cnt[i] + CW'(1);
         end
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign f.filt = s_q.out;

   // A rise needs the raw level high at both ends of the window
   property p_filt_rise;
      @(posedge clk_i) disable iff (!rst_n_i)
      $rose(s_q.out[0]) |-> $past(f.raw[0]) && $past(f.raw[0], COUNT);
   endproperty
   a_filt_rise: assert property (p_filt_rise)
      else $error("filter output rose without a stable raw window");

   if (!SYM) begin : g_fast
      // Fast release lands on the next edge
      property p_filt_fast_clear;
         @(posedge clk_i) disable iff (!rst_n_i)
         !f.raw[0] |=> !s_q.out[0];
      endproperty
      a_filt_fast_clear: assert property (p_filt_fast_clear)
         else $error("one-sided filter did not release on low input");
   end

endmodule : ipg_filter

// File: rtl/ipg_gate_protect.sv
// Protection and gate-gating core for a three-phase inverter driver.
// Assumes comparator results arrive as digital levels synchronous to
// clk_i, and that the fault line has an external pull-up.
`timescale 1ns/10ps
module ipg_gate_protect
   import ipg_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [2:0] high_phase_input_i,
   input wire logic [2:0] low_phase_input_i,
   input wire logic high_shutdown_input_i,
   input wire logic shunt_sense_limit_i,
   input wire logic shunt_sense_trip_i,
   input wire logic [2:0] high_supply_stop_i,
   input wire logic [2:0] high_supply_start_i,
   input wire logic low_supply_stop_i,
   input wire logic low_supply_start_i,
   input wire logic thermal_trip_i,
   input wire logic thermal_release_i,
   input wire logic fault_line_i,
   output logic fault_line_o,
   output logic fault_line_oe_n_o,
   output logic [2:0] high_gate_cmd_o,
   output logic [2:0] low_gate_cmd_o,
   output logic current_limit_flag_o
);

   // Whole state of the core
   typedef struct packed {
      logic [2:0] hs_uv;        // High supply undervoltage per phase
      logic ls_uv;              // Low supply undervoltage
      logic [2:0] hs_lock;      // High gate held off until a rising edge
      logic [2:0] hin_prev;     // Last high command, for edge detection
      logic current_limit_flag;                // Current limiting active
      logic thermal_shutdown;                // Thermal shutdown active
      ipg_ocp_state_t ocp_st;   // Trip sequencer
      logic [HOLD_W-1:0] hold;  // Remaining hold cycles
      logic fault_oe_n;         // Fault line release (low = pulled low)
      logic [2:0] hgate;        // Registered high gate commands
      logic [2:0] lgate;        // Registered low gate commands
   } ipg_state_t;

   // High gates start locked so nothing turns on before a fresh edge
   localparam ipg_state_t RESET_STATE = '{
      hs_uv: 3'h0, ls_uv: 1'b0, hs_lock: 3'h7, hin_prev: 3'h0,
      current_limit_flag: 1'b0, thermal_shutdown: 1'b0, ocp_st: OCP_IDLE, hold: '0,
      fault_oe_n: 1'b1, hgate: 3'h0, lgate: 3'h0};

   ipg_state_t s_q;
   ipg_state_t s_d;

   // Filter carriers
   ipg_filt_if #(.W(UV_W)) uv_if ();
   ipg_filt_if #(.W(1)) sd_if ();
   ipg_filt_if #(.W(1)) fo_if ();
   ipg_filt_if #(.W(1)) ocl_if ();
   ipg_filt_if #(.W(1)) ocp_if ();

   // Raw indications into the filters
   assign uv_if.raw = {low_supply_start_i, low_supply_stop_i,
                       high_supply_start_i, high_supply_stop_i};
   assign sd_if.raw = high_shutdown_input_i;
   assign fo_if.raw = ~fault_line_i; // Line low counts as asserted
   assign ocl_if.raw = shunt_sense_limit_i;
   assign ocp_if.raw = shunt_sense_trip_i;

   // Supply filters; start and stop levels both filtered
   ipg_filter #(.W(UV_W), .COUNT(UV_FILT_CYC), .SYM(1'b1))
      u_uv_filt (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .f(uv_if.flt)
   );

   // Shutdown input filter, both edges
   ipg_filter #(.W(1), .COUNT(SD_FILT_CYC), .SYM(1'b1)) u_sd_filt (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .f(sd_if.flt)
   );

   // External shutdown on the fault line; released as soon as it goes high
   ipg_filter #(.W(1), .COUNT(FO_IN_CYC), .SYM(1'b0)) u_fo_filt (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .f(fo_if.flt)
   );

   // Limit blanking; drop below the reference clears at once
   ipg_filter #(.W(1), .COUNT(BLANK_CYC), .SYM(1'b0)) u_ocl_blank (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .f(ocl_if.flt)
   );

   // Trip blanking; the hold timer keeps the fault after release
   ipg_filter #(.W(1), .COUNT(BLANK_CYC), .SYM(1'b0)) u_ocp_blank (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .f(ocp_if.flt)
   );

   // Filtered levels
   logic [2:0] hs_stop_f;
   logic [2:0] hs_start_f;
   logic ls_stop_f;
   logic ls_start_f;
   logic sd_f;
   logic fo_ext_f;
   logic ocp_f;
   logic ocp_hold_q;
   logic [2:0] hin_rise;
   logic [2:0] hs_block;

   assign hs_stop_f = uv_if.filt[UV_HS_STOP_LSB +: PHASES];
   assign hs_start_f = uv_if.filt[UV_HS_START_LSB +: PHASES];
   assign ls_stop_f = uv_if.filt[UV_LS_STOP_BIT];
   assign ls_start_f = uv_if.filt[UV_LS_START_BIT];
   assign sd_f = sd_if.filt[0];
   assign fo_ext_f = fo_if.filt[0];
   assign ocp_f = ocp_if.filt[0];
   assign ocp_hold_q = (s_q.ocp_st == OCP_HOLD);

   // Edge detect and lock causes per phase
   assign hin_rise = high_phase_input_i & ~s_q.hin_prev;
   assign hs_block = s_q.hs_uv | {PHASES{s_q.ls_uv | s_q.current_limit_flag}};

   // Next-state logic for all protections and gates
   always_comb begin
      s_d = s_q;
      s_d.hin_prev = high_phase_input_i;
      // Supply hysteresis: stop wins over start if both seen
      for (int i = 0; i < PHASES; i++) begin
         if (hs_stop_f[i]) begin
            s_d.hs_uv[i] = 1'b1;
         end else if (hs_start_f[i]) begin
            s_d.hs_uv[i] = 1'b0;
         end
      end
      if (ls_stop_f) begin
         s_d.ls_uv = 1'b1;
      end else if (ls_start_f) begin
         s_d.ls_uv = 1'b0;
      end
      // Current limit follows the blanked comparator
      s_d.current_limit_flag = ocl_if.filt[0];
      // Thermal hysteresis
      if (thermal_trip_i) begin
         s_d.thermal_shutdown = 1'b1;
      end else if (thermal_release_i) begin
         s_d.thermal_shutdown = 1'b0;
      end
      // Trip sequencer; a trip seen again restarts the hold
      unique case (s_q.ocp_st)
         OCP_IDLE: begin
            if (ocp_f) begin
               s_d.ocp_st = OCP_HOLD;
               s_d.hold = HOLD_W'(OCP_HOLD_CYC - 1);
            end
         end
         OCP_HOLD: begin
            if (ocp_f) begin
               s_d.hold = HOLD_W'(OCP_HOLD_CYC - 1);
            end else if (s_q.hold == '0) begin
               s_d.ocp_st = OCP_IDLE;
            end else begin
               s_d.hold = s_q.hold - HOLD_W'(1);
            end
         end
      endcase
      // Lock each high gate while a cause holds, free it on a rising edge
      for (int i = 0; i < PHASES; i++) begin
         if (hs_block[i]) begin
            s_d.hs_lock[i] = 1'b1;
         end else if (hin_rise[i]) begin
            s_d.hs_lock[i] = 1'b0;
         end
      end
      // High gates: command and no lock and no shutdown input
      s_d.hgate = high_phase_input_i & ~s_d.hs_lock
                  & ~{PHASES{sd_f}};
      // Low gates follow commands even while limiting
      s_d.lgate = low_phase_input_i
                  & ~{PHASES{s_q.ls_uv | ocp_hold_q | s_q.thermal_shutdown | fo_ext_f}};
      // Only low supply, trip hold and thermal pull the fault line
      s_d.fault_oe_n = ~(s_q.ls_uv | ocp_hold_q | s_q.thermal_shutdown);
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= RESET_STATE;
      end else begin
         s_q <= s_d;
      end
   end

   // Open-drain fault line only ever pulls low
   assign fault_line_o = 1'b0;
   assign fault_line_oe_n_o = s_q.fault_oe_n;
   assign high_gate_cmd_o = s_q.hgate;
   assign low_gate_cmd_o = s_q.lgate;
   assign current_limit_flag_o = s_q.current_limit_flag;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // Undervoltage on a high supply blocks that gate next cycle
   property p_hs_uv_off;
      s_q.hs_uv[0] |=> !high_gate_cmd_o[0];
   endproperty
   a_hs_uv_off: assert property (p_hs_uv_off)
      else $error("high gate on during high supply undervoltage");

   // A held-high command must not reopen the gate after recovery
   property p_hs_wait_edge;
      $fell(s_q.hs_uv[0]) && !s_q.ls_uv && !s_q.current_limit_flag && s_q.hs_lock[0]
         && high_phase_input_i[0] && s_q.hin_prev[0]
      |=> !high_gate_cmd_o[0];
   endproperty
   a_hs_wait_edge: assert property (p_hs_wait_edge)
      else $error("high gate resumed without a rising command");

   // High supply loss alone leaves the fault line released
   property p_hs_uv_no_fault;
      (s_q.hs_uv != 3'h0) && !s_q.ls_uv && !ocp_hold_q && !s_q.thermal_shutdown
      |=> fault_line_oe_n_o;
   endproperty
   a_hs_uv_no_fault: assert property (p_hs_uv_no_fault)
      else $error("fault line pulled by high supply undervoltage");

   // A fresh stop level needs the full filter before it counts
   property p_uv_filter;
      !s_q.ls_uv && !ls_stop_f && $rose(low_supply_stop_i)
      |=> !s_q.ls_uv [*8];
   endproperty
   a_uv_filter: assert property (p_uv_filter)
      else $error("low supply undervoltage taken without filtering");

   // Low supply loss stops every gate and pulls the fault line
   property p_ls_uv_all_off;
      s_q.ls_uv |=> (low_gate_cmd_o == 3'h0) && (high_gate_cmd_o == 3'h0)
                    && !fault_line_oe_n_o;
   endproperty
   a_ls_uv_all_off: assert property (p_ls_uv_all_off)
      else $error("gates on or fault released in low undervoltage");

   // Limiting must not disturb the low-side commands
   property p_ocl_low_follow;
      s_q.current_limit_flag && !s_q.ls_uv && !ocp_hold_q && !s_q.thermal_shutdown && !fo_ext_f
      |=> low_gate_cmd_o == $past(low_phase_input_i);
   endproperty
   a_ocl_low_follow: assert property (p_ocl_low_follow)
      else $error("low gates did not follow commands while limiting");

   // Flag drops two edges after the sense level falls
   property p_ocl_clear;
      !shunt_sense_limit_i |-> ##2 !current_limit_flag_o;
   endproperty
   a_ocl_clear: assert property (p_ocl_clear)
      else $error("limit flag stayed high after sense fell");

   // Trip hold keeps low gates off and the fault line low
   property p_trip_off;
      ocp_hold_q |=> (low_gate_cmd_o == 3'h0) && !fault_line_oe_n_o;
   endproperty
   a_trip_off: assert property (p_trip_off)
      else $error("low gates on or fault released during trip");

   // Hold counter starts full, so the fault lasts the whole time
   property p_trip_hold;
      $rose(ocp_hold_q) |-> ocp_hold_q [*8] ##0
         (s_q.hold > HOLD_W'(OCP_HOLD_CYC - 9));
   endproperty
   a_trip_hold: assert property (p_trip_hold)
      else $error("trip hold did not load its full count");

   // Over temperature stops the low gates and flags a fault
   property p_tsd_off;
      s_q.thermal_shutdown |=> (low_gate_cmd_o == 3'h0) && !fault_line_oe_n_o;
   endproperty
   a_tsd_off: assert property (p_tsd_off)
      else $error("low gates on or fault released in thermal shutdown");

   // Filtered shutdown input overrides every high command
   property p_sd_off;
      sd_f |=> high_gate_cmd_o == 3'h0;
   endproperty
   a_sd_off: assert property (p_sd_off)
      else $error("high gate on while shutdown input active");

   // Flag rises only after the limit level held through blanking
   property p_ocl_blanked;
      $rose(current_limit_flag_o) |-> $past(shunt_sense_limit_i, 2)
         && $past(shunt_sense_limit_i, BLANK_CYC + 1);
   endproperty
   a_ocl_blanked: assert property (p_ocl_blanked)
      else $error("limit flag rose before the blanking time ran out");

   // Low gates resume with the commands as soon as low supply returns
   property p_ls_recover;
      $fell(s_q.ls_uv) && !ocp_hold_q && !s_q.thermal_shutdown && !fo_ext_f
      |=> low_gate_cmd_o == $past(low_phase_input_i);
   endproperty
   a_ls_recover: assert property (p_ls_recover)
      else $error("low gates did not resume after low supply recovery");

   // Leaving thermal shutdown alone releases the fault line
   property p_tsd_release;
      $fell(s_q.thermal_shutdown) && !s_q.ls_uv && !ocp_hold_q |=> fault_line_oe_n_o;
   endproperty
   a_tsd_release: assert property (p_tsd_release)
      else $error("fault line still pulled after thermal release");

   // A long enough external low stops every low gate
   property p_fo_ext_off;
      fo_ext_f |=> low_gate_cmd_o == 3'h0;
   endproperty
   a_fo_ext_off: assert property (p_fo_ext_off)
      else $error("low gates on while fault line held low outside");

   c_ls_uv: cover property ($rose(s_q.ls_uv));
   c_trip: cover property ($fell(ocp_hold_q));
   c_limit: cover property ($rose(current_limit_flag_o));
   c_thermal: cover property ($fell(s_q.thermal_shutdown));

endmodule : ipg_gate_protect

// File: verif/ipg_ctrl_model.sv
// Behavioural model of the motor controller that feeds the phase commands.
// Assumes the fault line it watches is the resolved wire with its pull-up.
`timescale 1ns/10ps
module ipg_ctrl_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic fault_line_i, // Resolved fault wire, low = fault
   input wire logic obey_i, // 0 = keeps driving through a fault
   input wire logic [2:0] high_set_i, // Wanted high-side commands
   input wire logic [2:0] low_set_i, // Wanted low-side commands
   output logic [2:0] high_phase_o, // Registered high-side commands
   output logic [2:0] low_phase_o // Registered low-side commands
);
   // Commands move one edge after the wish; a seen fault drops them
   // Ignoring faults is a deliberate misbehaviour the bench switches on
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         high_phase_o <= 3'h0;
         low_phase_o <= 3'h0;
      end else if (obey_i && !fault_line_i) begin
         high_phase_o <= 3'h0;
         low_phase_o <= 3'h0;
      end else begin
         high_phase_o <= high_set_i;
         low_phase_o <= low_set_i;
      end
   end
endmodule : ipg_ctrl_model

// File: verif/inverter_protection_gating_test.sv
// Self-checking bench for the protection and gate-gating core.
// Assumes the fault line has a pull-up; the bench may also pull it low.
`timescale 1ns/10ps
module inverter_protection_gating_test;
   import ipg_pkg::*;

   typedef struct packed {
      logic k; // 0 = gates, 1 = status
      logic [5:0] v; // Expected value
   } ipg_note_t;

   logic clk;
   logic rst_n;
   logic [2:0] hset, lset, hs_stop, hs_start, lv;
   logic obey, sd, lim, trip, ls_stop, ls_start, th_trip, th_rel, ext_n;
   logic fault_o, oe_n, flag;
   logic [2:0] hg, lg, hph, lph;
   wire fline; // Resolved open-drain fault wire
   int fail_count, total_checks, cyc, seed;
   ipg_note_t q[$]; // Expected results, oldest first
   ipg_note_t note;

   // Pull-up, device pull-down, bench pull-down
   assign fline = (oe_n ? 1'b1 : fault_o) & ext_n;

   ipg_gate_protect dut (
      .clk_i(clk), .rst_n_i(rst_n),
      .high_phase_input_i(hph), .low_phase_input_i(lph),
      .high_shutdown_input_i(sd),
      .shunt_sense_limit_i(lim), .shunt_sense_trip_i(trip),
      .high_supply_stop_i(hs_stop), .high_supply_start_i(hs_start),
      .low_supply_stop_i(ls_stop), .low_supply_start_i(ls_start),
      .thermal_trip_i(th_trip), .thermal_release_i(th_rel),
      .fault_line_i(fline), .fault_line_o(fault_o),
      .fault_line_oe_n_o(oe_n), .high_gate_cmd_o(hg),
      .low_gate_cmd_o(lg), .current_limit_flag_o(flag)
   );

   ipg_ctrl_model ctrl (
      .clk_i(clk), .rst_n_i(rst_n), .fault_line_i(fline),
      .obey_i(obey), .high_set_i(hset), .low_set_i(lset),
      .high_phase_o(hph), .low_phase_o(lph)
   );

   // 40 MHz logic clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Verdict, reached from the main sequence or the timeout
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask : step

   // Note expected gates, checked at the next falling edge
   task automatic exp_g(input logic [2:0] h, input logic [2:0] l);
      q.push_back({1'b0, h, l});
   endtask : exp_g

   // Note expected limit flag and fault enable
   task automatic exp_s(input logic f, input logic o);
      q.push_back({1'b1, 4'h0, f, o});
   endtask : exp_s

   task automatic cmp_gates(input logic [5:0] e);
      total_checks++;
      if ({hg, lg} !== e) begin
         fail_count++;
         $display("[FAIL] %0t gates %h want %h", $time, {hg, lg}, e);
      end
   endtask : cmp_gates

   task automatic cmp_status(input logic [1:0] e);
      total_checks++;
      if ({flag, oe_n} !== e || fault_o !== 1'b0) begin
         fail_count++;
         $display("[FAIL] %0t status %b want %b", $time,
                  {flag, oe_n, fault_o}, {e, 1'b0});
      end
   endtask : cmp_status

   // All three high wishes low then high: a fresh rising edge per phase
   task automatic redo_high();
      hset <= 3'h0;
      step(2);
      hset <= 3'h7;
      step(3);
   endtask : redo_high

   // Monitor: outputs are settled mid-cycle, drain all notes there
   always @(negedge clk) begin
      while (q.size() > 0) begin
         note = q.pop_front();
         if (note.k) begin
            cmp_status(note.v[1:0]);
         end else begin
            cmp_gates(note.v);
         end
      end
   end

   // Hang guard, well above the few thousand cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 10000) begin
         fail_count++;
         final_report();
      end
   end

   // Main sequence
   initial begin
      seed = 66;
      rst_n = 1'b0;
      {hset, lset, hs_stop, lv} = 12'h000;
      {obey, sd, lim, trip, ls_stop, th_trip} = 6'h00;
      hs_start = 3'h7;
      {ls_start, th_rel, ext_n} = 3'h7;
      step(8);
      exp_g(3'h0, 3'h0);
      exp_s(1'b0, 1'b1);
      rst_n <= 1'b1;
      step(2);
      // Random low commands reach the gates, high ones unlock
      repeat (4) begin
         lv = 3'($random(seed));
         lset <= lv;
         hset <= 3'h7;
         step(3);
         exp_g(3'h7, lv);
      end
      // High supply of phase 0 drops, then recovers
      hs_stop <= 3'h1;
      hs_start <= 3'h6;
      step(100);
      exp_g(3'h7, lv);
      step(30);
      exp_g(3'h6, lv);
      exp_s(1'b0, 1'b1);
      hs_stop <= 3'h0;
      hs_start <= 3'h7;
      step(130);
      exp_g(3'h6, lv);
      redo_high();
      exp_g(3'h7, lv);
      // Low supply drops, then recovers
      ls_stop <= 1'b1;
      ls_start <= 1'b0;
      step(100);
      exp_s(1'b0, 1'b1);
      step(30);
      exp_g(3'h0, 3'h0);
      exp_s(1'b0, 1'b0);
      ls_stop <= 1'b0;
      ls_start <= 1'b1;
      step(130);
      exp_g(3'h0, lv);
      exp_s(1'b0, 1'b1);
      redo_high();
      exp_g(3'h7, lv);
      // Current limit, low commands changing meanwhile
      lim <= 1'b1;
      step(70);
      exp_s(1'b0, 1'b1);
      step(15);
      exp_s(1'b1, 1'b1);
      lv = 3'($random(seed));
      lset <= lv;
      step(3);
      exp_g(3'h0, lv);
      lim <= 1'b0;
      step(3);
      exp_s(1'b0, 1'b1);
      exp_g(3'h0, lv);
      redo_high();
      exp_g(3'h7, lv);
      // Overcurrent trip and its hold time
      lim <= 1'b1;
      trip <= 1'b1;
      step(70);
      exp_g(3'h7, lv);
      step(15);
      exp_g(3'h0, 3'h0);
      exp_s(1'b1, 1'b0);
      lim <= 1'b0;
      trip <= 1'b0;
      step(900);
      exp_s(1'b0, 1'b0);
      step(120);
      exp_s(1'b0, 1'b1);
      exp_g(3'h0, lv);
      redo_high();
      // Thermal shutdown with hysteresis; the controller obeys the fault
      obey <= 1'b1;
      th_trip <= 1'b1;
      th_rel <= 1'b0;
      step(3);
      exp_g(3'h7, 3'h0);
      exp_s(1'b0, 1'b0);
      th_trip <= 1'b0;
      step(300);
      exp_g(3'h0, 3'h0);
      exp_s(1'b0, 1'b0);
      th_rel <= 1'b1;
      step(5);
      exp_g(3'h7, lv);
      exp_s(1'b0, 1'b1);
      // High-side shutdown input
      obey <= 1'b0;
      sd <= 1'b1;
      step(120);
      exp_g(3'h7, lv);
      step(20);
      exp_g(3'h0, lv);
      sd <= 1'b0;
      step(140);
      redo_high();
      // Fault line pulled low from outside
      ext_n <= 1'b0;
      step(200);
      exp_g(3'h7, lv);
      step(50);
      exp_g(3'h7, 3'h0);
      exp_s(1'b0, 1'b1);
      ext_n <= 1'b1;
      step(4);
      exp_g(3'h7, lv);
      step(3);
      final_report();
   end
endmodule : inverter_protection_gating_test
